// file: design/harvester_power_path_gating.sv
// power-path and power-gating switch control with AXI4-Lite registers
//
// Function
// R1: battery-only, battery detected: both battery-to-output switches on.
// R2: battery undetected: both battery-to-output switches off.
// R3: solar plus battery, store below upper: battery switches and solar charge on.
// R4: store at upper limit: battery switches off, store switches on.
// R5: store at reconnect level: solar charge back on, store switches stay on.
// R6: store at lower limit: store switches off, battery switches back on.
// R7: store switches return when store next reaches upper limit.
// R8: surplus store present: surplus charge on at store upper limit.
// R9: surplus charge off below second solar level, back on at second detect.
// R10: surplus charge off at store reconnect level.
// R11: surplus charge off when surplus store reaches its upper limit.
// R12: from surplus store: solar charge on at reconnect, store switches off at lower.
// R13: gating mode latched from two straps when internal supply is first detected.
// R14: energy mode solar: store switches on from upper to lower limit.
// R15: energy mode battery: battery switches on from detect to undetect.
// R16: event mode 1: output one as energy mode, output two follows request.
// R17: event modes: hold-off runs from power-up, flags, masks request.
// R18: event mode 2: request starts window timer, output two on while it runs.
// R19: event mode 2: timers reset on lower limit or battery undetect.
// R20: timer mode: both outputs governed only by timer flags.
// R21: timer mode: hold-off and window start at power-up and each off-period end.
// R22: timer mode: output one on in window; output two after hold-off.
// R23: timer mode: resets on lower limit, supply loss, battery undetect.
// R24: durations are cycle counts; thresholds arrive as synchronised detect bits.
// R25: mode held until supply lost; all switches off without supply.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module harvester_power_path_gating #(
  parameter int TIMER_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic internal_supply_det,
  input wire logic solar_det,
  input wire logic solar_second_det,
  input wire logic battery_det,
  input wire logic store_upper_det,
  input wire logic store_reconnect_low,
  input wire logic store_lower_low,
  input wire logic surplus_present,
  input wire logic surplus_upper_det,
  input wire logic request,
  input wire logic window_time_strap,
  input wire logic [1:0] off_period_time_strap,
  output logic out1_store_switch,
  output logic out2_store_switch,
  output logic out1_battery_switch,
  output logic out2_battery_switch,
  output logic solar_charge_switch,
  output logic surplus_charge_switch,
  output logic holdoff_flag,
  output logic window_flag,
  output logic off_period_flag,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    harvester_gating_pkg::mode_e mode;
    logic supply_prev;
    logic avail_prev;
    logic on_batt_prev;
    logic store_on;
    logic charge_stop;
    logic surplus_arm;
    logic [5:0] sw;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0][TIMER_W-1:0] dur;
  } ctrl_s;

  ctrl_s s_reg;
  ctrl_s s_next;

  if (TIMER_W < 2 || TIMER_W > 32) begin : g_check
    $error("TIMER_W must be 2 to 32");
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [12:0] pins;
  logic [12:0] lv;
  logic sup;
  logic sol;
  logic sol2;
  logic bat;
  logic up;
  logic rec;
  logic low;
  logic spres;
  logic sfull;
  logic req;
  logic [2:0] straps;

  assign pins = {internal_supply_det, solar_det, solar_second_det, battery_det, store_upper_det,
                 store_reconnect_low, store_lower_low, surplus_present, surplus_upper_det, request,
                 window_time_strap, off_period_time_strap};

  level_sync #(.WIDTH(13)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pins),
    .level_out(lv)
  ); // R24

  assign {sup, sol, sol2, bat, up, rec, low, spres, sfull, req} = lv[12:3];
  assign straps = lv[2:0];

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic harvester_gating_pkg::mode_e strap_mode(input logic [2:0] st);
    if (!st[2] && st[1:0] == harvester_gating_pkg::STRAP_GROUND) begin
      strap_mode = harvester_gating_pkg::MODE_EVENT1;
    end else if (st[2] && st[1:0] == harvester_gating_pkg::STRAP_CAP) begin
      strap_mode = harvester_gating_pkg::MODE_TIMER;
    end else if (st[2]) begin
      strap_mode = harvester_gating_pkg::MODE_EVENT2;
    end else begin
      strap_mode = harvester_gating_pkg::MODE_ENERGY;
    end
  endfunction

  // returns {hit, index}
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    unique case (a)
      harvester_gating_pkg::HOLDOFF_OFFSET: reg_index = 3'b100;
      harvester_gating_pkg::WINDOW_OFFSET: reg_index = 3'b101;
      harvester_gating_pkg::OFF_PERIOD_OFFSET: reg_index = 3'b110;
      harvester_gating_pkg::STATUS_OFFSET: reg_index = 3'b111;
      default: reg_index = 3'b000;
    endcase
  endfunction

  // ************************************************************
  // timers
  // ************************************************************
  logic [2:0] t_start;
  logic [2:0] t_clear;
  logic [2:0] t_run;
  logic [2:0] t_done;

  for (genvar i = 0; i < 3; i++) begin : g_timer
    gate_timer #(.W(TIMER_W)) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(t_start[i]),
      .clear(t_clear[i]),
      .duration(s_reg.dur[i]),
      .running(t_run[i]),
      .done(t_done[i])
    );
  end

  // ************************************************************
  // power path
  // ************************************************************
  logic store_on_n;
  logic avail;
  logic trig;
  logic lose;
  logic g1;
  logic g2;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic [31:0] status;

  // lower limit wins over upper so a collapsing store always opens
  assign store_on_n = sup && !low && (up || s_reg.store_on); // R4 R6 R7 R14
  assign avail = store_on_n || bat;
  assign trig = avail && !s_reg.avail_prev;
  assign lose = !avail && s_reg.avail_prev;

  always_comb begin
    t_start = 3'b000;
    t_clear = 3'b000;
    // hold-off and window drop with the source or supply; off-period only on supply loss or battery loss
    t_clear[0] = !sup || lose; // R19 R23
    t_clear[1] = !sup || lose; // R19 R23
    t_clear[2] = !sup || (lose && s_reg.on_batt_prev); // R23
    g1 = 1'b1;
    g2 = 1'b1;
    unique case (s_reg.mode)
      harvester_gating_pkg::MODE_ENERGY: begin
        g1 = 1'b1;
      end
      harvester_gating_pkg::MODE_EVENT1: begin
        t_start[0] = trig; // R17
        g2 = req && !t_run[0]; // R16 R17
      end
      harvester_gating_pkg::MODE_EVENT2: begin
        t_start[0] = trig; // R17
        t_start[1] = req && !t_run[0] && !t_run[1] && avail; // R18
        g2 = t_run[1]; // R18
      end
      harvester_gating_pkg::MODE_TIMER: begin
        t_start[0] = trig || t_done[2]; // R21
        t_start[1] = trig || t_done[2]; // R21
        t_start[2] = t_done[1]; // R21
        g1 = t_run[1]; // R20 R22
        g2 = t_run[1] && !t_run[0]; // R20 R22
      end
    endcase
  end

  assign wsel = reg_index(s_reg.awaddr);
  assign rsel = reg_index(araddr);

  always_comb begin
    status = '0;
    status[harvester_gating_pkg::STAT_SWITCH_LSB +: 6] = s_reg.sw;
    status[harvester_gating_pkg::STAT_FLAG_LSB +: 3] = t_run;
    status[harvester_gating_pkg::STAT_SUPPLY_BIT] = sup;
    status[harvester_gating_pkg::STAT_MODE_LSB +: 2] = s_reg.mode;
  end

  always_comb begin
    s_next = s_reg;
    s_next.supply_prev = sup;
    s_next.avail_prev = avail;
    s_next.on_batt_prev = bat && !store_on_n;
    s_next.store_on = store_on_n;
    if (sup && !s_reg.supply_prev) begin
      s_next.mode = strap_mode(straps); // R13 R25
    end
    if (up) begin
      s_next.charge_stop = 1'b1;
    end else if (rec) begin
      s_next.charge_stop = 1'b0; // R5 R12
    end
    if (up && spres) begin
      s_next.surplus_arm = 1'b1; // R8
    end else if (rec || !spres) begin
      s_next.surplus_arm = 1'b0; // R10
    end
    // switch order {surplus, solar, out2 bat, out1 bat, out2 store, out1 store}
    s_next.sw[0] = store_on_n && g1; // R14 R22
    s_next.sw[1] = store_on_n && g2; // R16 R22
    s_next.sw[2] = bat && !store_on_n && g1; // R1 R2 R3 R15
    s_next.sw[3] = bat && !store_on_n && g2; // R1 R2 R16
    s_next.sw[4] = sol && !(up || (s_reg.charge_stop && !rec)); // R3 R5 R12
    s_next.sw[5] = s_next.surplus_arm && spres && sol2 && !sfull; // R9 R11
    if (!sup) begin
      s_next.sw = '0; // R25
      s_next.charge_stop = 1'b0;
      s_next.surplus_arm = 1'b0;
    end

    // register bus
    if (awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.awaddr = awaddr;
    end
    if (wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wsel[2] ? harvester_gating_pkg::RESP_OKAY : harvester_gating_pkg::RESP_DECERR;
      // status is read-only; writes there are accepted and dropped
      if (wsel[2] && wsel[1:0] != 2'b11) begin
        for (int b = 0; b < 4; b++) begin
          if (s_reg.wstrb[b] && 8 * b < TIMER_W) begin
            s_next.dur[wsel[1:0]][8 * b +: 8] = s_reg.wdata[8 * b +: 8];
          end
        end
      end
    end
    s_next.awready = !s_next.aw_held;
    s_next.wready = !s_next.w_held;
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = rsel[2] ? harvester_gating_pkg::RESP_OKAY : harvester_gating_pkg::RESP_DECERR;
      if (!rsel[2]) begin
        s_next.rdata = '0;
      end else if (rsel[1:0] == 2'b11) begin
        s_next.rdata = status;
      end else begin
        s_next.rdata = 32'(s_reg.dur[rsel[1:0]]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.mode <= harvester_gating_pkg::MODE_ENERGY;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.dur[0] <= TIMER_W'(harvester_gating_pkg::HOLDOFF_RESET);
      s_reg.dur[1] <= TIMER_W'(harvester_gating_pkg::WINDOW_RESET);
      s_reg.dur[2] <= TIMER_W'(harvester_gating_pkg::OFF_PERIOD_RESET);
    end else begin
      s_reg <= s_next;
    end
  end

  assign out1_store_switch = s_reg.sw[0];
  assign out2_store_switch = s_reg.sw[1];
  assign out1_battery_switch = s_reg.sw[2];
  assign out2_battery_switch = s_reg.sw[3];
  assign solar_charge_switch = s_reg.sw[4];
  assign surplus_charge_switch = s_reg.sw[5];
  assign holdoff_flag = t_run[0];
  assign window_flag = t_run[1];
  assign off_period_flag = t_run[2];
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_ready;
    s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  endsequence
  sequence s_wr_answer;
    bvalid ##0 (bresp == harvester_gating_pkg::RESP_OKAY || bresp == harvester_gating_pkg::RESP_DECERR);
  endsequence

  property p_batt_on;
    (s_reg.mode == harvester_gating_pkg::MODE_ENERGY && sup && bat && !up && !s_reg.store_on)
      |=> out1_battery_switch && out2_battery_switch;
  endproperty
  a_batt_on: assert property (p_batt_on) else $error("battery switches not on"); // R1

  property p_batt_off;
    !bat |=> !out1_battery_switch && !out2_battery_switch;
  endproperty
  a_batt_off: assert property (p_batt_off) else $error("battery switches not off"); // R2

  property p_store_on;
    (s_reg.mode == harvester_gating_pkg::MODE_ENERGY && sup && up && !low)
      |=> out1_store_switch && out2_store_switch && !out1_battery_switch;
  endproperty
  a_store_on: assert property (p_store_on) else $error("store switches not on at upper"); // R4

  property p_store_low;
    low |=> !out1_store_switch && !out2_store_switch;
  endproperty
  a_store_low: assert property (p_store_low) else $error("store switches on at lower"); // R6

  property p_surplus_off;
    (sfull || !sol2) |=> !surplus_charge_switch;
  endproperty
  a_surplus_off: assert property (p_surplus_off) else $error("surplus charge not off"); // R9 R11

  property p_no_supply;
    !sup |=> s_reg.sw == 6'h00;
  endproperty
  a_no_supply: assert property (p_no_supply) else $error("switch on without supply"); // R25

  property p_mode_latch;
    (sup && !s_reg.supply_prev) |=> s_reg.mode == strap_mode($past(straps));
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not latched"); // R13

  property p_holdoff_mask;
    (s_reg.mode == harvester_gating_pkg::MODE_EVENT1 && t_run[0]) |=> !out2_store_switch && !out2_battery_switch;
  endproperty
  a_holdoff_mask: assert property (p_holdoff_mask) else $error("request not masked"); // R17

  property p_off_period;
    (s_reg.mode == harvester_gating_pkg::MODE_TIMER && t_run[2] && !t_run[1])
      |=> !out1_store_switch && !out1_battery_switch;
  endproperty
  a_off_period: assert property (p_off_period) else $error("output one on in off period"); // R22

  property p_wr_resp;
    s_wr_ready |=> s_wr_answer;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");

endmodule // harvester_power_path_gating

// file: design/harvester_gating_pkg.sv
// constants, register map and types shared by the power-path gating block
package harvester_gating_pkg;

  // ************************************************************
  // register bus
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] HOLDOFF_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] WINDOW_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ************************************************************
  // timer durations after reset, in aclk cycles
  // ************************************************************
  localparam logic [DATA_W-1:0] HOLDOFF_RESET = 32'h0000_03E8;
  localparam logic [DATA_W-1:0] WINDOW_RESET = 32'h0000_07D0;
  localparam logic [DATA_W-1:0] OFF_PERIOD_RESET = 32'h0000_0FA0;

  // ************************************************************
  // status word layout
  // ************************************************************
  localparam int STAT_SWITCH_LSB = 0;
  localparam int STAT_FLAG_LSB = 6;
  localparam int STAT_SUPPLY_BIT = 9;
  localparam int STAT_MODE_LSB = 10;

  // ************************************************************
  // strap codes and gating modes
  // ************************************************************
  localparam logic [1:0] STRAP_OPEN = 2'h0;
  localparam logic [1:0] STRAP_GROUND = 2'h1;
  localparam logic [1:0] STRAP_CAP = 2'h2;

  typedef enum logic [1:0] {
    MODE_ENERGY = 2'b00,
    MODE_EVENT1 = 2'b01,
    MODE_EVENT2 = 2'b10,
    MODE_TIMER = 2'b11
  } mode_e;

endpackage

// file: design/level_sync.sv
// three-stage synchroniser with agreement filter for pin levels
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] level;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1) begin : g_check
    $error("level_sync needs at least one bit");
  end

  // a change counts only once stages two and three agree
  assign agree = ~(s_reg.ff2 ^ s_reg.ff3);

  always_comb begin
    s_next = s_reg;
    s_next.ff1 = pin_in;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    s_next.level = (s_reg.level & ~agree) | (s_reg.ff3 & agree);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_out = s_reg.level;

endmodule // level_sync

// file: design/gate_timer.sv
// one-shot duration timer with run flag and completion pulse
module gate_timer #(
  parameter int W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic clear,
  input wire logic [W-1:0] duration,
  output logic running,
  output logic done
);

  typedef struct packed {
    logic running;
    logic done;
    logic [W-1:0] count;
  } timer_s;

  timer_s s_reg;
  timer_s s_next;
  logic [W-1:0] last;

  if (W < 2 || W > 32) begin : g_check
    $error("gate_timer width must be 2 to 32");
  end

  // zero duration behaves as one cycle
  assign last = (duration == '0) ? '0 : duration - W'(1);

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (clear) begin
      s_next.running = 1'b0;
      s_next.count = '0;
    end else if (s_reg.running) begin
      if (s_reg.count >= last) begin
        s_next.running = 1'b0;
        s_next.done = 1'b1;
        s_next.count = '0;
      end else begin
        s_next.count = s_reg.count + W'(1);
      end
    end else if (start) begin
      s_next.running = 1'b1;
      s_next.count = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign running = s_reg.running;
  assign done = s_reg.done;

  property p_start;
    @(posedge aclk) disable iff (!aresetn)
    (start && !clear && !s_reg.running) |=> running;
  endproperty
  a_start: assert property (p_start) else $error("timer did not start"); // R17 R21

endmodule // gate_timer

// file: testbench/load_model.sv
// load-side partner: drives the request input with a lag
module load_model #(
  parameter int LAG = 3
) (
  input wire logic aclk,
  input wire logic want,
  output logic request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LAG-1:0] pipe_reg = '0;
  // ************************************************************
  // slow answer, so the bench cannot lean on a prompt load
  // ************************************************************
  always @(posedge aclk) begin
    pipe_reg <= {pipe_reg[LAG-2:0], want};
  end
  assign request = pipe_reg[LAG-1];
endmodule // load_model

// file: testbench/harvester_power_path_gating_tb.sv
// self-checking bench for the power-path gating block
module harvester_power_path_gating_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0;
  logic aresetn = 0;
  logic want = 0;
  logic request;
  logic [11:0] p = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rd, seed = 32'h8C4E;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] rsp, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, hf, wf, of;
  logic [31:0] rdata;
  logic [5:0] sw;
  int error_cnt = 0, checks_done = 0, cyc = 0, n, k;
  // pin vector: 0 supply 1 solar 2 second 3 battery 4 upper 5 reconnect 6 lower 7 surplus 8 full 9 win 11:10 off
  logic [11:0] sv[9] = '{12'h009, 12'h08F, 12'h09F, 12'h09B, 12'h09F, 12'h19F, 12'h0AF, 12'h0EF, 12'h0E7};
  logic [5:0] se[9] = '{6'h0C, 6'h1C, 6'h23, 6'h03, 6'h23, 6'h03, 6'h13, 6'h1C, 6'h10};

  harvester_power_path_gating i_harvester_power_path_gating (.aclk(aclk), .aresetn(aresetn),
    .internal_supply_det(p[0]), .solar_det(p[1]), .solar_second_det(p[2]), .battery_det(p[3]),
    .store_upper_det(p[4]), .store_reconnect_low(p[5]), .store_lower_low(p[6]), .surplus_present(p[7]),
    .surplus_upper_det(p[8]), .request(request), .window_time_strap(p[9]), .off_period_time_strap(p[11:10]),
    .out1_store_switch(sw[0]), .out2_store_switch(sw[1]), .out1_battery_switch(sw[2]),
    .out2_battery_switch(sw[3]), .solar_charge_switch(sw[4]), .surplus_charge_switch(sw[5]),
    .holdoff_flag(hf), .window_flag(wf), .off_period_flag(of), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  load_model i_load_model (.aclk(aclk), .want(want), .request(request));

  // ************************************************************
  // clock, hang guard, verdict
  // ************************************************************
  initial forever #4 aclk = ~aclk;

  task automatic complete_run;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // whole run is well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [11:0] straps(input int m);
    return {(m == 1) ? 2'h1 : (m == 3) ? 2'h2 : 2'h0, m[1], 9'h001};
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  // sync chain plus partner lag stay well inside 10 edges
  task automatic step(input logic [11:0] v, input logic [5:0] e);
    @(posedge aclk);
    p <= v;
    repeat (10) @(posedge aclk);
    chk(32'(e), 32'(sw));
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'h0, {23'h0, of, wf, hf, sw});
    axr(8'h00, rd, rsp);
    chk(harvester_gating_pkg::HOLDOFF_RESET, rd);
    axr(8'h04, rd, rsp);
    chk(harvester_gating_pkg::WINDOW_RESET, rd);
    axr(8'h08, rd, rsp);
    chk(harvester_gating_pkg::OFF_PERIOD_RESET, rd);
    axr(8'h10, rd, rsp);
    chk(32'(harvester_gating_pkg::RESP_DECERR), 32'(rsp));
    axw(harvester_gating_pkg::STATUS_OFFSET, 32'hFFF, rsp);
    chk(32'(harvester_gating_pkg::RESP_OKAY), 32'(rsp));
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      axw(harvester_gating_pkg::WINDOW_OFFSET, seed, rsp);
      axr(harvester_gating_pkg::WINDOW_OFFSET, rd, rsp);
      chk(seed, rd);
    end
    for (k = 0; k < 9; k++) step(sv[k], se[k]);
    step(12'h09F, 6'h23);
    axr(harvester_gating_pkg::STATUS_OFFSET, rd, rsp);
    chk(32'h1, 32'(rd[11:9]));
    step(12'h09E, 6'h00);
    for (k = 0; k < 4; k++) begin
      step(12'h000, 6'h00);
      step(straps(k), 6'h00);
      axr(harvester_gating_pkg::STATUS_OFFSET, rd, rsp);
      chk(32'(k), 32'(rd[11:10]));
    end
    seed = xs(seed);
    n = 12 + int'(seed[3:0]);
    axw(harvester_gating_pkg::HOLDOFF_OFFSET, 32'(n), rsp);
    step(12'h000, 6'h00);
    step(12'h401, 6'h00);
    // request raised first: it must be ignored while hold-off runs
    want <= 1'b1;
    @(posedge aclk);
    p <= 12'h409;
    for (k = 0; k < 40 && hf !== 1'b1; k++) @(posedge aclk);
    for (k = 0; k < 100 && hf === 1'b1; k++) begin
      @(posedge aclk);
      if (k == 8) chk(32'h04, 32'(sw));
    end
    chk(32'(n), 32'(k));
    step(12'h409, 6'h0C);
    want <= 1'b0;
    step(12'h409, 6'h04);
    step(12'h009, 6'h04);
    axr(harvester_gating_pkg::STATUS_OFFSET, rd, rsp);
    chk(32'h1, 32'(rd[11:10]));
    // timer mode on battery: short window and off-period so a full cycle fits
    axw(harvester_gating_pkg::WINDOW_OFFSET, 32'h28, rsp);
    axw(harvester_gating_pkg::OFF_PERIOD_OFFSET, 32'h14, rsp);
    step(12'h000, 6'h00);
    step(12'hA01, 6'h00);
    step(12'hA09, 6'h04);
    for (k = 0; k < 100 && hf === 1'b1; k++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk(32'h0C, 32'(sw));
    for (k = 0; k < 200 && of !== 1'b1; k++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk(32'h00, 32'(sw));
    for (k = 0; k < 200 && of === 1'b1; k++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk(32'h1, 32'(wf));
    complete_run();
  end
endmodule // harvester_power_path_gating_tb
